/* pkg/tks_map.svh */
/* Register offsets, field positions, reset values and counts of the touch key scan sequencer.
   Assumes a 32-bit Avalon-MM slave with byte addresses, one register per word. */
`ifndef TKS_MAP_SVH
`define TKS_MAP_SVH
// Overview of operation
// [R1] A slot unit is 32 slot clocks, or one slot clock when bypassed.
// [R2] Slot overflow comes after (256 - preload) slot units.
// [R3] Owner bit 0 gives the data memory to the CPU, 1 to the module.
// [R4] Auto and periodic scans take memory priority until busy falls.
// [R5] Software should set the owner bit before auto or periodic scans.
// [R6] Hardware overflow sets the irq request, a software write does not.
// [R7] Software can set the overflow flag and must clear it itself.
// [R8] A mid-scan auto overflow clears counters and reloads, flag untouched.
// [R9] Auto scan end sets flag and irq and stops oscillators and counters.
// [R10] Periodic mode holds the flag low and sets it after the result store.
// [R11] Manual overflow sets flag and irq and stops oscillators and counters.
// [R12] Start low clears frequency and unit counters, not the slot counter.
// [R13] Start rising switches on the counters and the oscillators.
// [R14] Four sense keys share pins chosen by pin-share select bits.
// [R15] Mode 00 is auto, 01 manual, 10 and 11 periodic.
// [R16] Busy rises with start and falls at the end of each mode's scan.
// [R17] The slot counter loads the preload and counts units past 255.
`define TKS_OFS_PRELOAD 8'h00
`define TKS_OFS_MAIN 8'h04
`define TKS_OFS_CLKG 8'h08
`define TKS_OFS_PERIOD 8'h0C
`define TKS_OFS_REF_LO 8'h10
`define TKS_OFS_REF_HI 8'h14
`define TKS_OFS_KEY_LO 8'h18
`define TKS_OFS_KEY_HI 8'h1C
`define TKS_OFS_CAP_LO 8'h20
`define TKS_OFS_CAP_HI 8'h24
`define TKS_OFS_FILT 8'h28
`define TKS_OFS_ENAB 8'h2C
`define TKS_OFS_KSEQ 8'h30
`define TKS_OFS_TH_LO 8'h34
`define TKS_OFS_TH_HI 8'h38
`define TKS_OFS_THFS 8'h3C
`define TKS_OFS_IRQ_STAT 8'h40
`define TKS_OFS_IRQ_EN 8'h44
`define TKS_OFS_IRQ_CLR 8'h48
`define TKS_MAIN_OVF 6
`define TKS_MAIN_START 5
`define TKS_MAIN_CFOV 4
`define TKS_MAIN_R16OV 3
`define TKS_ENAB_BYPASS 7
`define TKS_ENAB_REFOSC 5
`define TKS_ENAB_KEYOSC 4
`define TKS_PERIOD_TSC 2
`define TKS_RST_MAIN 8'h02
`define TKS_RST_CLKG 8'h03
`define TKS_RST_PERIOD 3'h1
`define TKS_MASK_CLKG 8'hEF
`define TKS_MASK_FILT 8'h2F
`define TKS_MASK_ENAB 8'hBF
`define TKS_UNIT_WIDTH 5
`endif

/* pkg/tks_pkg.sv */
/* Types of the touch key scan sequencer.
   Assumes nothing beyond the constants header. */
package tks_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN = 3'b010,
    S_STORE = 3'b100
  } tks_state_type;
  typedef enum logic [1:0] {
    MODE_AUTO = 2'b00,
    MODE_MANUAL = 2'b01,
    MODE_PERIODIC = 2'b10,
    MODE_PERIODIC_ALT = 2'b11
  } tks_mode_type;
endpackage

/* pkg/tks_scan_if.sv */
/* Control and count signals between the sequencer, slot timer and counters.
   Assumes all three parties run on one clock. */
`timescale 1ns/10ps
`default_nettype none
interface tks_scan_if;
  logic run;
  logic clear;
  logic reload;
  logic bypass;
  logic [7:0] preload;
  logic [1:0] prescale;
  logic key_edge;
  logic slot_ovf;
  logic [15:0] key_count;
  logic [15:0] ref_count;
  logic key_ovf;
  logic ref_ovf;
  modport ctrl (output run, clear, reload, bypass, preload, prescale, key_edge,
    input slot_ovf, key_count, ref_count, key_ovf, ref_ovf);
  modport timer (input run, clear, reload, bypass, preload, output slot_ovf);
  modport counter (input run, clear, prescale, key_edge, output key_count, ref_count, key_ovf, ref_ovf);
endinterface
`default_nettype wire

/* hw/tks_slot_timer.sv */
/* Time slot unit divider and 8-bit time slot counter.
   Assumes its controls come from the sequencer on the same clock. */
`timescale 1ns/10ps
`default_nettype none
`include "tks_map.svh"

module tks_slot_timer #(
  parameter int UNIT_W = `TKS_UNIT_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  tks_scan_if.timer scan
);
  logic [UNIT_W-1:0] unit_q;
  logic [7:0] slot_q;
  logic unit_done;

  assign unit_done = scan.bypass | (&unit_q); // see [R1]
  assign scan.slot_ovf = scan.run & unit_done & (&slot_q); // see [R2]

  always_ff @(posedge clk) begin
    if (!reset_n || scan.clear || scan.reload) begin
      unit_q <= '0;
    end else if (scan.run) begin
      unit_q <= unit_q + 1'b1; // see [R1]
    end
  end

  // Wrapping straight to the preload keeps back-to-back slots exact
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slot_q <= 8'h00;
    end else if (scan.reload || scan.slot_ovf) begin
      slot_q <= scan.preload; // see [R17]
    end else if (scan.run && unit_done) begin
      slot_q <= slot_q + 8'h01; // see [R17]
    end
  end

  a_slot_bypass_time: assert property (@(posedge clk) disable iff (!reset_n) // see [R2]
    (scan.reload && scan.bypass && scan.preload == 8'hFE) ##1 (scan.run && scan.bypass && !scan.reload)[*2]
    |-> scan.slot_ovf && !$past(scan.slot_ovf))
    else $error("bypassed slot overflow not after two units");
endmodule // tks_slot_timer
`default_nettype wire

/* hw/tks_freq_counters.sv */
/* Key count (C/F) and reference count 16-bit counters with prescaler.
   Assumes key_edge is already synchronised to clk. */
`timescale 1ns/10ps
`default_nettype none

module tks_freq_counters (
  input wire logic clk,
  input wire logic reset_n,
  tks_scan_if.counter scan
);
  logic [15:0] key_q;
  logic [15:0] ref_q;
  logic [2:0] div_q;
  logic ref_tick;

  always_comb begin
    unique case (scan.prescale)
      2'b00: ref_tick = 1'b1;
      2'b01: ref_tick = div_q[0];
      2'b10: ref_tick = &div_q[1:0];
      2'b11: ref_tick = &div_q;
    endcase
  end

  // Clear wins over counting so a slot boundary never leaks a count
  always_ff @(posedge clk) begin
    if (!reset_n || scan.clear) begin
      key_q <= 16'h0000; // see [R12]
      ref_q <= 16'h0000; // see [R12]
      div_q <= 3'h0;
    end else if (scan.run) begin
      div_q <= div_q + 3'h1; // see [R13]
      if (scan.key_edge) begin
        key_q <= key_q + 16'h0001;
      end
      if (ref_tick) begin
        ref_q <= ref_q + 16'h0001;
      end
    end
  end

  assign scan.key_count = key_q;
  assign scan.ref_count = ref_q;
  assign scan.key_ovf = scan.run & scan.key_edge & (&key_q);
  assign scan.ref_ovf = scan.run & ref_tick & (&ref_q);
endmodule // tks_freq_counters
`default_nettype wire

/* hw/tks_scan_sequencer.sv */
/* Touch key scan sequencer top: Avalon-MM register file, scan state machine,
   flags, data memory ownership and interrupt.
   Assumes one 125 MHz clock, a synchronous active-low reset and key oscillator
   signals that arrive asynchronously on SENSE_INPUTS. */
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tks_map.svh"

module tks_scan_sequencer (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Avalon-MM register slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Touch key pins
  input wire logic [3:0] SENSE_INPUTS,
  output logic [3:0] PIN_SHARE_SEL,
  output logic KEY_OSC_EN,
  output logic REF_OSC_EN,
  // Data memory ownership and interrupt
  output logic DATA_RAM_MODULE,
  output logic RESULT_STORE,
  output logic IRQ
);
  localparam logic [7:0] RST_MAIN = `TKS_RST_MAIN;

  tks_scan_if scan ();

  tks_pkg::tks_state_type state_q;
  logic [7:0] preload_q;
  logic owner_q;
  logic ovf_flag_q;
  logic start_q;
  logic cfov_q;
  logic r16ov_q;
  logic [1:0] mode_q;
  logic busy_q;
  logic [7:0] clkg_q;
  logic [2:0] period_q;
  logic [7:0] cap_lo_q;
  logic [1:0] cap_hi_q;
  logic [7:0] filt_q;
  logic [7:0] enab_q;
  logic [7:0] kseq_q;
  logic [15:0] th_q;
  logic [3:0] ths_q;
  logic [3:0] thf_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic slot_idx_q;
  logic [3:0] scan_cnt_q;
  logic prio_q;
  logic [3:0] key_s1_q;
  logic [3:0] key_s2_q;
  logic [3:0] key_s3_q;
  logic [31:0] rdata;
  logic wr_en;
  logic wr_main;
  logic start_rise;
  logic start_fall;
  logic manual;
  logic periodic;
  logic [1:0] key_sel;
  logic slot_end;
  logic last_slot;
  logic last_scan;
  logic thr_hit;
  logic finish;
  logic thr_stop;
  logic next_slot;
  logic next_scan;
  logic store_go;
  logic hw_flag_set;

  tks_slot_timer u_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .scan(scan)
  );

  tks_freq_counters u_counters (
    .clk(CLK),
    .reset_n(RESET_N),
    .scan(scan)
  );

  // Bus slave: every access answers one cycle after it is seen
  assign wr_en = AVS_WRITE & ~AVS_WAITREQUEST;
  assign wr_main = wr_en && (AVS_ADDRESS == `TKS_OFS_MAIN);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b0;
    end else begin
      AVS_WAITREQUEST <= 1'b1;
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    case (AVS_ADDRESS)
      `TKS_OFS_PRELOAD: rdata[7:0] = preload_q;
      `TKS_OFS_MAIN: rdata[7:0] = {owner_q, ovf_flag_q, start_q, cfov_q, r16ov_q, mode_q, busy_q};
      `TKS_OFS_CLKG: rdata[7:0] = clkg_q;
      `TKS_OFS_PERIOD: rdata[2:0] = period_q;
      `TKS_OFS_REF_LO: rdata[7:0] = scan.ref_count[7:0];
      `TKS_OFS_REF_HI: rdata[7:0] = scan.ref_count[15:8];
      `TKS_OFS_KEY_LO: rdata[7:0] = scan.key_count[7:0];
      `TKS_OFS_KEY_HI: rdata[7:0] = scan.key_count[15:8];
      `TKS_OFS_CAP_LO: rdata[7:0] = cap_lo_q;
      `TKS_OFS_CAP_HI: rdata[1:0] = cap_hi_q;
      `TKS_OFS_FILT: rdata[7:0] = filt_q;
      `TKS_OFS_ENAB: rdata[7:0] = enab_q;
      `TKS_OFS_KSEQ: rdata[7:0] = kseq_q;
      `TKS_OFS_TH_LO: rdata[7:0] = th_q[7:0];
      `TKS_OFS_TH_HI: rdata[7:0] = th_q[15:8];
      `TKS_OFS_THFS: rdata[7:0] = {thf_q, ths_q};
      `TKS_OFS_IRQ_STAT: rdata[1:0] = irq_stat_q;
      `TKS_OFS_IRQ_EN: rdata[1:0] = irq_en_q;
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && AVS_WAITREQUEST) begin
      AVS_READDATA <= rdata;
    end
  end

  // Plain configuration registers
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      preload_q <= 8'h00;
      clkg_q <= `TKS_RST_CLKG;
      period_q <= `TKS_RST_PERIOD;
      cap_lo_q <= 8'h00;
      cap_hi_q <= 2'h0;
      filt_q <= 8'h00;
      enab_q <= 8'h00;
      kseq_q <= 8'h00;
      th_q <= 16'h0000;
      ths_q <= 4'h0;
      irq_en_q <= 2'h0;
    end else if (wr_en) begin
      case (AVS_ADDRESS)
        `TKS_OFS_PRELOAD: preload_q <= AVS_WRITEDATA[7:0];
        `TKS_OFS_CLKG: clkg_q <= AVS_WRITEDATA[7:0] & `TKS_MASK_CLKG;
        `TKS_OFS_PERIOD: period_q <= AVS_WRITEDATA[2:0];
        `TKS_OFS_CAP_LO: cap_lo_q <= AVS_WRITEDATA[7:0];
        `TKS_OFS_CAP_HI: cap_hi_q <= AVS_WRITEDATA[1:0];
        `TKS_OFS_FILT: filt_q <= AVS_WRITEDATA[7:0] & `TKS_MASK_FILT;
        `TKS_OFS_ENAB: enab_q <= AVS_WRITEDATA[7:0] & `TKS_MASK_ENAB;
        `TKS_OFS_KSEQ: kseq_q <= AVS_WRITEDATA[7:0];
        `TKS_OFS_TH_LO: th_q[7:0] <= AVS_WRITEDATA[7:0];
        `TKS_OFS_TH_HI: th_q[15:8] <= AVS_WRITEDATA[7:0];
        `TKS_OFS_THFS: ths_q <= AVS_WRITEDATA[3:0];
        `TKS_OFS_IRQ_EN: irq_en_q <= AVS_WRITEDATA[1:0];
        default: ;
      endcase
    end
  end

  // Software-owned fields of the main control register
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      owner_q <= RST_MAIN[7];
      start_q <= RST_MAIN[5];
      mode_q <= RST_MAIN[2:1];
    end else if (wr_main) begin
      owner_q <= AVS_WRITEDATA[7]; // see [R3]
      start_q <= AVS_WRITEDATA[`TKS_MAIN_START];
      mode_q <= AVS_WRITEDATA[2:1];
    end
  end

  // Sense pins are asynchronous: two flops, then a third for edge detection
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      key_s1_q <= 4'h0;
      key_s2_q <= 4'h0;
      key_s3_q <= 4'h0;
    end else begin
      key_s1_q <= SENSE_INPUTS; // see [R14]
      key_s2_q <= key_s1_q;
      key_s3_q <= key_s2_q;
    end
  end

  assign start_rise = wr_main & AVS_WRITEDATA[`TKS_MAIN_START] & ~start_q;
  assign start_fall = wr_main & ~AVS_WRITEDATA[`TKS_MAIN_START] & start_q;
  assign manual = (mode_q == tks_pkg::MODE_MANUAL); // see [R15]
  assign periodic = mode_q[1]; // see [R15]
  assign key_sel = slot_idx_q ? kseq_q[3:2] : kseq_q[1:0];
  assign slot_end = (state_q == tks_pkg::S_RUN) & scan.slot_ovf;
  assign last_slot = period_q[`TKS_PERIOD_TSC] | slot_idx_q;
  assign last_scan = (scan_cnt_q == ((4'h1 << period_q[1:0]) - 4'h1));
  assign thr_hit = periodic & enab_q[key_sel] &
    (ths_q[key_sel] ? (scan.key_count > th_q) : (scan.key_count < th_q));
  assign finish = slot_end & (manual | (last_slot & ~periodic)); // see [R11] [R9]
  assign thr_stop = slot_end & thr_hit;
  assign next_slot = slot_end & ~manual & ~last_slot & ~thr_hit; // see [R8]
  assign next_scan = slot_end & periodic & last_slot & ~last_scan & ~thr_hit;
  assign store_go = slot_end & periodic & last_slot & last_scan & ~thr_hit;
  assign hw_flag_set = finish | (state_q == tks_pkg::S_STORE);

  assign scan.run = (state_q == tks_pkg::S_RUN); // see [R13]
  assign scan.clear = start_fall | next_slot | next_scan; // see [R12] [R8]
  assign scan.reload = start_rise; // see [R17]
  assign scan.bypass = enab_q[`TKS_ENAB_BYPASS]; // see [R1]
  assign scan.preload = preload_q;
  assign scan.prescale = clkg_q[3:2];
  assign scan.key_edge = key_s2_q[key_sel] & ~key_s3_q[key_sel] & enab_q[key_sel];

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_q <= tks_pkg::S_IDLE;
    end else if (start_fall) begin
      state_q <= tks_pkg::S_IDLE;
    end else begin
      unique case (state_q)
        tks_pkg::S_IDLE: if (start_rise) state_q <= tks_pkg::S_RUN;
        tks_pkg::S_RUN: begin
          if (finish || thr_stop) begin
            state_q <= tks_pkg::S_IDLE;
          end else if (store_go) begin
            state_q <= tks_pkg::S_STORE; // see [R10]
          end
        end
        tks_pkg::S_STORE: state_q <= tks_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      busy_q <= 1'b0;
    end else if (start_fall) begin
      busy_q <= 1'b0;
    end else if (start_rise) begin
      busy_q <= 1'b1; // see [R16]
    end else if (finish || thr_stop || state_q == tks_pkg::S_STORE) begin
      busy_q <= 1'b0; // see [R16]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N || start_rise) begin
      slot_idx_q <= 1'b0;
      scan_cnt_q <= 4'h0;
    end else if (next_slot) begin
      slot_idx_q <= 1'b1;
    end else if (next_scan) begin
      slot_idx_q <= 1'b0;
      scan_cnt_q <= scan_cnt_q + 4'h1;
    end
  end

  // Priority follows the mode written with start; dropped once back in idle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      prio_q <= 1'b0;
    end else if (start_rise) begin
      prio_q <= (AVS_WRITEDATA[2:1] != tks_pkg::MODE_MANUAL); // see [R4]
    end else if (state_q == tks_pkg::S_IDLE) begin
      prio_q <= 1'b0; // see [R4]
    end
  end

  // Hardware sets win over software clears in every flag
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ovf_flag_q <= RST_MAIN[`TKS_MAIN_OVF];
      cfov_q <= RST_MAIN[`TKS_MAIN_CFOV];
      r16ov_q <= RST_MAIN[`TKS_MAIN_R16OV];
    end else begin
      if (hw_flag_set) begin
        ovf_flag_q <= 1'b1; // see [R9] [R11]
      end else if (periodic && (start_rise || busy_q)) begin
        ovf_flag_q <= 1'b0; // see [R10]
      end else if (wr_main) begin
        ovf_flag_q <= AVS_WRITEDATA[`TKS_MAIN_OVF]; // see [R7]
      end
      if (scan.key_ovf) begin
        cfov_q <= 1'b1;
      end else if (wr_main && !AVS_WRITEDATA[`TKS_MAIN_CFOV]) begin
        cfov_q <= 1'b0;
      end
      if (scan.ref_ovf) begin
        r16ov_q <= 1'b1;
      end else if (wr_main && !AVS_WRITEDATA[`TKS_MAIN_R16OV]) begin
        r16ov_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      thf_q <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (thr_stop && key_sel == 2'(k)) begin
          thf_q[k] <= 1'b1;
        end else if (wr_en && AVS_ADDRESS == `TKS_OFS_THFS && !AVS_WRITEDATA[k+4]) begin
          thf_q[k] <= 1'b0;
        end
      end
    end
  end

  // Status bit 0 is the overflow request, bit 1 the threshold event
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_en && AVS_ADDRESS == `TKS_OFS_IRQ_CLR) ? AVS_WRITEDATA[1:0] : 2'h0))
        | {thr_stop, hw_flag_set}; // see [R6]
    end
  end

  // Output flops; ownership lags its cause by one cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
      PIN_SHARE_SEL <= 4'h0;
      KEY_OSC_EN <= 1'b0;
      REF_OSC_EN <= 1'b0;
      DATA_RAM_MODULE <= 1'b0;
      RESULT_STORE <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_q & irq_en_q);
      PIN_SHARE_SEL <= enab_q[3:0]; // see [R14]
      KEY_OSC_EN <= busy_q & enab_q[`TKS_ENAB_KEYOSC]; // see [R13]
      REF_OSC_EN <= busy_q & enab_q[`TKS_ENAB_REFOSC]; // see [R13]
      DATA_RAM_MODULE <= owner_q | prio_q; // see [R3] [R4]
      RESULT_STORE <= store_go; // see [R10]
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_auto_done;
    slot_end && !manual && !periodic && last_slot;
  endsequence
  sequence s_flag_up_stopped;
    ovf_flag_q && irq_stat_q[0] && !busy_q && !scan.run ##1 !KEY_OSC_EN && !REF_OSC_EN;
  endsequence

  a_start_sets_busy: assert property ( // see [R16]
    start_rise |=> busy_q && scan.run)
    else $error("start did not raise busy");
  a_start_low_clear: assert property ( // see [R12]
    start_fall |=> scan.key_count == 16'h0000 && scan.ref_count == 16'h0000 && !busy_q)
    else $error("start low did not clear counters");
  a_manual_ovf_flag: assert property ( // see [R11]
    slot_end && manual |=> s_flag_up_stopped)
    else $error("manual overflow did not raise flag and stop");
  a_auto_midscan_noflag: assert property ( // see [R8]
    slot_end && !manual && !periodic && !last_slot && !ovf_flag_q && !wr_main
    |=> !ovf_flag_q && busy_q && scan.key_count == 16'h0000 && scan.ref_count == 16'h0000)
    else $error("mid-scan overflow set flag or kept counts");
  a_auto_done_flag: assert property ( // see [R9]
    s_auto_done |=> s_flag_up_stopped)
    else $error("auto scan end did not raise flag and stop");
  a_periodic_store_flag: assert property ( // see [R10]
    store_go && !start_fall |=> RESULT_STORE && !ovf_flag_q ##1 ovf_flag_q && !busy_q && irq_stat_q[0])
    else $error("periodic flag not set right after store");
  a_sw_flag_no_irq: assert property ( // see [R6]
    wr_main && AVS_WRITEDATA[`TKS_MAIN_OVF] && !irq_stat_q[0] && !hw_flag_set |=> !irq_stat_q[0])
    else $error("software flag write raised irq request");
  a_ram_priority: assert property ( // see [R4]
    start_rise && AVS_WRITEDATA[2:1] != tks_pkg::MODE_MANUAL |-> ##2 DATA_RAM_MODULE)
    else $error("auto scan did not take memory priority");
  a_owner_release: assert property ( // see [R3]
    $fell(busy_q) ##0 (!owner_q && !start_rise)[*2] |=> !DATA_RAM_MODULE)
    else $error("memory not returned to owner bit");
endmodule // tks_scan_sequencer
`default_nettype wire

/* test/tks_key_model.sv */
/* Electrode oscillator model of the four sense keys.
   Assumes the key oscillator enable comes from the sequencer. */
`timescale 1ns/10ps
`default_nettype none
module tks_key_model (
  // Oscillator enable
  input wire logic osc_en,
  // Key oscillator outputs
  output logic [3:0] sense
);
  initial sense = 4'h0;
  // Periods unrelated to CLK so the synchroniser sees real phase drift
  for (genvar k = 0; k < 4; k++) begin : g_key
    always begin
      #(21 + 6 * k);
      sense[k] = osc_en ? ~sense[k] : 1'b0;
    end
  end
endmodule // tks_key_model
`default_nettype wire

/* test/tks_scan_sequencer_tb_top.sv */
/* Self-checking bench of the scan sequencer: bus, scan modes, flags, irq.
   Assumes the constants header and the electrode model. */
`timescale 1ns/10ps
`default_nettype none
`include "tks_map.svh"
module tks_scan_sequencer_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wait_req;
  logic [3:0] sense;
  logic [3:0] pin_sel;
  logic key_en;
  logic ref_en;
  logic ram_module;
  logic store;
  logic irq;
  logic ien = 1'b0;
  logic [63:0] note;
  logic [63:0] rd_q[$];
  int len_q[$];
  int lexp;
  int run_len = 0;
  int stores = 0;
  int mismatches = 0;
  int samples_checked = 0;

  tks_scan_sequencer dut (.CLK(clk), .RESET_N(reset_n), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .SENSE_INPUTS(sense), .PIN_SHARE_SEL(pin_sel), .KEY_OSC_EN(key_en), .REF_OSC_EN(ref_en),
    .DATA_RAM_MODULE(ram_module), .RESULT_STORE(store), .IRQ(irq));
  tks_key_model keys (.osc_en(key_en), .sense(sense));

  always #4 clk = ~clk;

  task automatic close_out;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic hang;
    mismatches++;
    close_out;
  endtask

  task automatic cmp(input logic [31:0] o, input logic [31:0] e);
    samples_checked++;
    if (o !== e) begin
      mismatches++;
      $display("BAD t=%0t obs=%h exp=%h", $time, o, e);
    end
  endtask

  // Starts on a fresh edge so a release is never undone in the same step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdata <= d;
    wr_en <= wr;
    rd_en <= ~wr;
    do begin
      @(posedge clk);
      if (++n > 50) hang;
    end while (wait_req !== 1'b0);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back({m, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic look;
    repeat (2) @(negedge clk);
  endtask

  always @(posedge clk) begin
    if (rd_en && wait_req === 1'b0 && rd_q.size() > 0) begin
      note = rd_q.pop_front();
      cmp(rdata & note[63:32], note[31:0]);
    end
  end

  // Oscillator-on time is the measured scan length; a few cycles of slack for hand-over
  always @(posedge clk) begin
    if (store === 1'b1) stores <= stores + 1;
    if (ref_en === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      run_len <= 0;
      if (len_q.size() > 0) begin
        lexp = len_q.pop_front();
        if (lexp >= 0) begin
          samples_checked++;
          if (run_len > lexp + 6 || run_len < lexp - 6) begin
            mismatches++;
            $display("BAD t=%0t len=%h exp=%h", $time, run_len, lexp);
          end
        end
      end
    end
  end

  task automatic scan(input logic [1:0] mode, input logic byp, input logic tsc, input int slots,
    input logic own);
    logic [7:0] p;
    logic [3:0] ks;
    int n;
    int s0;
    // Single bypassed slots take the two-unit preload that the slot timer check watches
    p = (slots == 1 && byp) ? 8'hFE : 8'hF0 + 8'($urandom % 9);
    ks = 4'($urandom % 15 + 1);
    n = 0;
    s0 = stores;
    wr(`TKS_OFS_ENAB, {byp, 1'b0, 2'b11, ks});
    look;
    cmp(32'(pin_sel), 32'(ks));
    wr(`TKS_OFS_PERIOD, {5'h00, tsc, 2'b01});
    wr(`TKS_OFS_PRELOAD, p);
    len_q.push_back(slots * (256 - p) * (byp ? 1 : 32));
    wr(`TKS_OFS_MAIN, {own, 2'b01, 2'b00, mode, 1'b0});
    look;
    cmp(32'(ram_module), 32'(own | (mode != 2'b01)));
    while (len_q.size() > 0) begin
      @(posedge clk);
      if (++n > 20000) hang;
    end
    rd(`TKS_OFS_MAIN, {24'h00_0000, own, 2'b11, 2'b00, mode, 1'b0}, 32'h0000_00E7);
    rd(`TKS_OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
    look;
    cmp(32'(irq), 32'(ien));
    cmp(32'(ram_module), 32'(own));
    cmp(32'(key_en), 32'h0000_0000);
    cmp(32'(stores - s0), 32'(mode[1]));
    wr(`TKS_OFS_IRQ_CLR, 8'h01);
    wr(`TKS_OFS_MAIN, {own, 4'h0, mode, 1'b0});
    look;
    cmp(32'(irq), 32'h0000_0000);
  endtask

  logic [1:0] t_mode[5] = '{2'b01, 2'b00, 2'b00, 2'b10, 2'b11};
  logic t_tsc[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  int t_slots[5] = '{1, 2, 1, 4, 2};
  logic t_own[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

  initial begin
    void'($urandom(49397));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd(`TKS_OFS_PRELOAD, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`TKS_OFS_MAIN, 32'h0000_0002, 32'hFFFF_FFFF);
    rd(`TKS_OFS_CLKG, 32'h0000_0003, 32'hFFFF_FFFF);
    rd(`TKS_OFS_PERIOD, 32'h0000_0001, 32'hFFFF_FFFF);
    rd(8'h80, 32'h0000_0000, 32'hFFFF_FFFF);
    // Masked interrupt first, with the 32-clock slot unit
    scan(2'b01, 1'b0, 1'b0, 1, 1'b0);
    wr(`TKS_OFS_IRQ_EN, 8'h01);
    ien = 1'b1;
    t_own[0] = 1'($urandom % 2);
    // The auto scan after a manual one keeps owner 0 so that only the priority can hand over memory
    for (int i = 0; i < 5; i++) begin
      scan(t_mode[i], 1'b1, t_tsc[i], t_slots[i], t_own[i]);
    end
    // A software 1 in the flag must not raise the request
    wr(`TKS_OFS_MAIN, 8'h42);
    rd(`TKS_OFS_IRQ_STAT, 32'h0000_0000, 32'h0000_0001);
    rd(`TKS_OFS_MAIN, 32'h0000_0040, 32'h0000_0040);
    wr(`TKS_OFS_MAIN, 8'h02);
    // Long manual scan aborted by start low
    wr(`TKS_OFS_ENAB, 8'h3F);
    wr(`TKS_OFS_PRELOAD, 8'h00);
    len_q.push_back(-1);
    wr(`TKS_OFS_MAIN, 8'h22);
    repeat (100) @(posedge clk);
    rd(`TKS_OFS_MAIN, 32'h0000_0023, 32'h0000_0063);
    wr(`TKS_OFS_MAIN, 8'h02);
    rd(`TKS_OFS_REF_LO, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`TKS_OFS_REF_HI, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`TKS_OFS_KEY_LO, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`TKS_OFS_KEY_HI, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`TKS_OFS_IRQ_STAT, 32'h0000_0000, 32'h0000_0001);
    // Periodic scan stopped by a threshold hit: event request only, no overflow flag
    wr(`TKS_OFS_TH_HI, 8'hFF);
    wr(`TKS_OFS_ENAB, 8'hBF);
    wr(`TKS_OFS_PRELOAD, 8'hF0);
    len_q.push_back(16);
    wr(`TKS_OFS_MAIN, 8'h24);
    for (int n = 0; len_q.size() > 0; n++) begin
      @(posedge clk);
      if (n > 2000) hang;
    end
    rd(`TKS_OFS_THFS, 32'h0000_0010, 32'h0000_00F0);
    rd(`TKS_OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0003);
    rd(`TKS_OFS_MAIN, 32'h0000_0020, 32'h0000_0061);
    repeat (20) @(posedge clk);
    close_out;
  end
endmodule // tks_scan_sequencer_tb_top
`default_nettype wire
